// file: rtl/lcz_pkg.sv
package lcz_pkg;

   // clock and time base
   localparam int unsigned CLK_PERIOD_NS   = 8;
   localparam int unsigned TIME_UNIT_MS    = 10;
   localparam int unsigned TIME_UNIT_CYC   = (TIME_UNIT_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned TIME_W          = 9;

   // startup window limits, in 10 ms units
   localparam logic [8:0]  INTV_MIN_LIMIT  = 9'h1F2;  // 4.98 s
   localparam logic [8:0]  INTV_MAX_LOW    = 9'h002;  // 0.02 s
   localparam logic [8:0]  INTV_MAX_LIMIT  = 9'h1F4;  // 5 s
   // automatic restart delay, 10 ms units
   localparam logic [8:0]  RESTART_DLY_RST = 9'h00A;  // 100 ms
   // start button press window, 10 ms units
   localparam logic [8:0]  BTN_PRESS_MIN   = 9'h003;  // 30 ms
   localparam logic [8:0]  BTN_PRESS_MAX   = 9'h190;  // 4 s

   // beam parameter types, index into the control vector
   localparam int unsigned TYPE_FIXED      = 0;
   localparam int unsigned TYPE_FLOAT      = 1;
   localparam int unsigned TYPE_REDRES     = 2;
   localparam int unsigned TYPE_BEAMSIG    = 3;
   localparam int unsigned NUM_TYPES       = 4;

   typedef enum logic [1:0] {
      LCZ_START_NONE,
      LCZ_START_INTV,
      LCZ_START_BTN
   } lcz_start_mode_t;

   typedef struct packed {
      logic [TIME_W-1:0] intv_min;
      logic [TIME_W-1:0] intv_max;
      logic [TIME_W-1:0] restart_dly;
   } lcz_time_cfg_t;

   typedef struct packed {
      logic sig1;
      logic sig2;
   } lcz_beam_sig_t;

endpackage

// file: rtl/lcz_zone_start.sv
`timescale 1ns/10ps
module lcz_zone_start
   import lcz_pkg::*;
#(
   parameter int unsigned NUM_BEAMS = 16,
   parameter int unsigned TICK_CYC  = TIME_UNIT_CYC
) (
   input  wire logic                  REF_CLK,
   input  wire logic                  NRST,
   input  wire logic                  CE,
   input  wire logic [NUM_BEAMS-1:0]  BEAM_BLOCKED,
   input  wire logic [NUM_TYPES-1:0]  CTL_IN,
   input  wire logic                  START_BTN,
   input  wire logic                  SAFETY_CIRCUIT_CLOSED,
   input  wire logic [NUM_TYPES-1:0]  CTL_ASSIGNED,
   input  wire logic [NUM_BEAMS-1:0]  ZONE_FIXED,
   input  wire logic [NUM_BEAMS-1:0]  ZONE_FLOAT,
   input  wire logic [NUM_BEAMS-1:0]  ZONE_REDRES,
   input  wire logic [NUM_BEAMS-1:0]  ZONE_SIG1,
   input  wire logic [NUM_BEAMS-1:0]  ZONE_SIG2,
   input  wire logic [3:0]            TOL_BEAMS,
   input  wire lcz_start_mode_t       START_MODE,
   input  wire logic                  RESTART_MANUAL,
   input  wire logic                  SAFETY_CIRCUIT_USED,
   input  wire lcz_time_cfg_t         TIME_CFG,
   output logic                       SAFETY_SWITCHING_OUTPUT,
   output lcz_beam_sig_t              BEAM_SIG,
   output logic [NUM_TYPES-1:0]       CTL_FEEDBACK_N,
   output logic                       FIELD_FREE,
   output logic                       LOCKED,
   output logic                       STARTUP_DONE
);

   typedef enum logic [2:0] {
      S_INIT, S_INTV, S_BTN, S_RUN, S_DELAY, S_LOCK
   } lcz_state_t;

   function automatic logic [TIME_W-1:0] sat_inc(input logic [TIME_W-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [NUM_BEAMS-1:0] beam_s1_r, beam_r;
   logic [NUM_TYPES-1:0] ctl_s1_r, ctl_r;
   logic [1:0]           pin_s1_r, pin_r;

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         beam_s1_r <= '0;
         beam_r    <= '0;
         ctl_s1_r  <= '0;
         ctl_r     <= '0;
         pin_s1_r  <= '0;
         pin_r     <= '0;
      end else if (CE) begin
         beam_s1_r <= BEAM_BLOCKED;
         beam_r    <= beam_s1_r;
         ctl_s1_r  <= CTL_IN;
         ctl_r     <= ctl_s1_r;
         pin_s1_r  <= {START_BTN, SAFETY_CIRCUIT_CLOSED};
         pin_r     <= pin_s1_r;
      end
   end

   logic btn;
   logic circ_ok;
   assign btn     = pin_r[1];
   assign circ_ok = !SAFETY_CIRCUIT_USED || pin_r[0];

   ////////////////////////////////////////////////////////////////////////////
   // beam parameter type enables
   logic [NUM_TYPES-1:0] type_en, type_en_r;
   logic                 type_chg;

   assign type_en  = ~CTL_ASSIGNED | ctl_r;
   assign type_chg = (type_en != type_en_r);

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         type_en_r      <= '1;
         CTL_FEEDBACK_N <= '1;
      end else if (CE) begin
         type_en_r      <= type_en;
         CTL_FEEDBACK_N <= ~ctl_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field evaluation
   logic       viol;
   logic [3:0] run;

   always_comb begin
      viol = 1'b0;
      run  = '0;
      for (int i = 0; i < NUM_BEAMS; i++) begin
         if (beam_r[i] && ZONE_REDRES[i] && type_en[TYPE_REDRES]) begin
            run = (&run) ? run : run + 4'h1;
         end else begin
            if (run > TOL_BEAMS) viol = 1'b1;
            run = '0;
            if (beam_r[i]
                && !(ZONE_FIXED[i] && type_en[TYPE_FIXED])
                && !(ZONE_FLOAT[i] && type_en[TYPE_FLOAT]))
               viol = 1'b1;
         end
      end
      if (run > TOL_BEAMS) viol = 1'b1;
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         BEAM_SIG   <= '0;
         FIELD_FREE <= 1'b0;
      end else if (CE) begin
         BEAM_SIG.sig1 <= type_en[TYPE_BEAMSIG] && |(beam_r & ZONE_SIG1);
         BEAM_SIG.sig2 <= type_en[TYPE_BEAMSIG] && |(beam_r & ZONE_SIG2);
         FIELD_FREE    <= !viol;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // 10 ms time base; shorten TICK_CYC in simulation
   logic [31:0] pre_r;
   logic        tick;
   assign tick = (pre_r == 32'(TICK_CYC - 1));

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)        pre_r <= '0;
      else if (CE)      pre_r <= tick ? '0 : pre_r + 32'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // start button press and release
   logic              btn_d_r;
   logic [TIME_W-1:0] btn_cnt_r;
   logic              btn_ok;

   assign btn_ok = btn_d_r && !btn && btn_cnt_r >= BTN_PRESS_MIN
                   && btn_cnt_r <= BTN_PRESS_MAX;

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         btn_d_r   <= 1'b0;
         btn_cnt_r <= '0;
      end else if (CE) begin
         btn_d_r <= btn;
         if (!btn)      btn_cnt_r <= '0;
         else if (tick) btn_cnt_r <= sat_inc(btn_cnt_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // intervention duration and restart delay counting
   logic              viol_d_r;
   logic [TIME_W-1:0] int_cnt_r, dly_cnt_r;
   logic              intv_end, intv_ok;

   assign intv_end = viol_d_r && !viol;
   assign intv_ok  = intv_end && int_cnt_r >= TIME_CFG.intv_min
                     && int_cnt_r <= TIME_CFG.intv_max;

   lcz_state_t st_r, st_nxt;

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         viol_d_r  <= 1'b0;
         int_cnt_r <= '0;
         dly_cnt_r <= '0;
      end else if (CE) begin
         viol_d_r <= viol;
         if (!viol)     int_cnt_r <= '0;
         else if (tick) int_cnt_r <= sat_inc(int_cnt_r);
         if (st_r != S_DELAY || viol || !circ_ok) dly_cnt_r <= '0;
         else if (tick)                           dly_cnt_r <= sat_inc(dly_cnt_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // startup and restart sequencing
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         S_INIT: begin
            // window used only in intervention mode
            case (START_MODE)
               LCZ_START_INTV: st_nxt = S_INTV;
               LCZ_START_BTN:  st_nxt = S_BTN;
               default:        st_nxt = S_RUN;
            endcase
         end
         S_INTV:  if (intv_ok) st_nxt = S_RUN;
         S_BTN:   if (btn_ok) st_nxt = S_RUN;
         S_RUN: begin
            if (RESTART_MANUAL && type_chg)         st_nxt = S_LOCK;
            else if (viol || !circ_ok)              st_nxt = RESTART_MANUAL ? S_LOCK : S_DELAY;
         end
         S_DELAY: begin
            if (dly_cnt_r >= TIME_CFG.restart_dly && !viol && circ_ok) st_nxt = S_RUN;
         end
         S_LOCK:  if (btn_ok && !viol && circ_ok) st_nxt = S_RUN;
         default: st_nxt = S_INIT;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)   st_r <= S_INIT;
      else if (CE) st_r <= st_nxt;
   end

   // output turns off on the edge after a violation is seen, in step with FIELD_FREE, so both lag viol by one register
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         SAFETY_SWITCHING_OUTPUT <= 1'b0;
         LOCKED                  <= 1'b0;
         STARTUP_DONE            <= 1'b0;
      end else if (CE) begin
         SAFETY_SWITCHING_OUTPUT <= (st_nxt == S_RUN) && !viol && circ_ok;
         LOCKED                  <= (st_nxt == S_LOCK);
         STARTUP_DONE            <= (st_nxt == S_RUN) || (st_nxt == S_DELAY)
                                    || (st_nxt == S_LOCK) || STARTUP_DONE;
      end
   end

endmodule

// file: testbench/lcz_zone_start_properties.sv
`timescale 1ns/10ps
module lcz_zone_start_chk
   import lcz_pkg::*;
#(
   parameter int unsigned NUM_BEAMS = 16
) (
   input wire logic                 REF_CLK,
   input wire logic                 NRST,
   input wire logic                 CE,
   input wire logic [NUM_BEAMS-1:0] BEAM_BLOCKED,
   input wire logic [NUM_BEAMS-1:0] ZONE_SIG1,
   input wire logic [NUM_BEAMS-1:0] ZONE_SIG2,
   input wire logic [NUM_TYPES-1:0] CTL_IN,
   input wire logic [NUM_TYPES-1:0] CTL_ASSIGNED,
   input wire logic                 SAFETY_SWITCHING_OUTPUT,
   input wire lcz_beam_sig_t        BEAM_SIG,
   input wire logic [NUM_TYPES-1:0] CTL_FEEDBACK_N,
   input wire logic                 FIELD_FREE,
   input wire logic                 LOCKED,
   input wire logic                 STARTUP_DONE
);
   logic [2:0] up_r;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   // edges since reset or freeze; keeps $past clear of the sync pipeline fill
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         up_r <= 3'h0;
      end else if (!CE) begin
         up_r <= 3'h0;
      end else if (up_r != 3'h7) begin
         up_r <= up_r + 3'h1;
      end
   end
   //////////////////////////////////////////////////
   sequence s_back;
      up_r == 3'h7 && $rose(FIELD_FREE) && $past(STARTUP_DONE);
   endsequence
   property p_fb_inv;
      up_r == 3'h7 |-> CTL_FEEDBACK_N == ~$past(CTL_IN, 3);
   endproperty
   // type enable: assignment is same-domain, the control input is synced
   property p_sig1;
      up_r == 3'h7
         |-> BEAM_SIG.sig1 == ((!$past(CTL_ASSIGNED[TYPE_BEAMSIG])
                                || $past(CTL_IN[TYPE_BEAMSIG], 3))
                               && |($past(BEAM_BLOCKED, 3) & $past(ZONE_SIG1)));
   endproperty
   property p_sig2;
      up_r == 3'h7
         |-> BEAM_SIG.sig2 == ((!$past(CTL_ASSIGNED[TYPE_BEAMSIG])
                                || $past(CTL_IN[TYPE_BEAMSIG], 3))
                               && |($past(BEAM_BLOCKED, 3) & $past(ZONE_SIG2)));
   endproperty
   property p_free_off;
      !FIELD_FREE |-> !SAFETY_SWITCHING_OUTPUT;
   endproperty
   property p_lock_off;
      LOCKED |-> !SAFETY_SWITCHING_OUTPUT;
   endproperty
   property p_on_free;
      up_r == 3'h7 && $rose(SAFETY_SWITCHING_OUTPUT) |-> FIELD_FREE;
   endproperty
   property p_done_hold;
      !$fell(STARTUP_DONE);
   endproperty
   property p_restart;
      s_back |-> !SAFETY_SWITCHING_OUTPUT [*4];
   endproperty
   a_fb_inv: assert property (p_fb_inv) else $error("feedback not inverse");
   a_sig1: assert property (p_sig1) else $error("zone signal 1 wrong");
   a_sig2: assert property (p_sig2) else $error("zone signal 2 wrong");
   a_free_off: assert property (p_free_off) else $error("output on in violation");
   a_lock_off: assert property (p_lock_off) else $error("output on while locked");
   a_on_free: assert property (p_on_free) else $error("output on, field busy");
   a_done_hold: assert property (p_done_hold) else $error("startup done dropped");
   a_restart: assert property (p_restart) else $error("restart too early");
endmodule

bind lcz_zone_start lcz_zone_start_chk #(.NUM_BEAMS(NUM_BEAMS)) u_chk (
   .REF_CLK(REF_CLK), .NRST(NRST), .CE(CE), .BEAM_BLOCKED(BEAM_BLOCKED),
   .ZONE_SIG1(ZONE_SIG1), .ZONE_SIG2(ZONE_SIG2), .CTL_IN(CTL_IN), .CTL_ASSIGNED(CTL_ASSIGNED),
   .SAFETY_SWITCHING_OUTPUT(SAFETY_SWITCHING_OUTPUT), .BEAM_SIG(BEAM_SIG),
   .CTL_FEEDBACK_N(CTL_FEEDBACK_N), .FIELD_FREE(FIELD_FREE), .LOCKED(LOCKED),
   .STARTUP_DONE(STARTUP_DONE));

// file: testbench/lcz_plc_model.sv
`timescale 1ns/10ps
module lcz_plc_model #(
   parameter int unsigned FB_WIN = 8
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [3:0] req,
   input  wire logic [3:0] fb_n,
   output logic      [3:0] ctl,
   output logic            fb_err
);
   int unsigned wait_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctl <= 4'h0;
      end else begin
         ctl <= req;
      end
   end
   //////////////////////////////////////////////////
   // inverse echo window
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_r <= 0;
         fb_err <= 1'h0;
      end else if (fb_n === ~ctl) begin
         wait_r <= 0;
      end else begin
         wait_r <= wait_r + 1;
         if (wait_r >= FB_WIN) begin
            fb_err <= 1'h1;
         end
      end
   end
endmodule

// file: testbench/tb_lcz_zone_start.sv
`timescale 1ns/10ps
module tb_lcz_zone_start;
   import lcz_pkg::*;
   logic            clk = 1'h0, nrst = 1'h0, btn = 1'h0, man = 1'h0, circ = 1'h1;
   logic            cused = 1'h0, sso, ffree, lck, done, fb_err;
   logic            ce = 1'h1;
   logic [7:0]      zflt = 8'h00;
   logic [7:0]      beam = 8'h00, zfix = 8'h00, zred = 8'h00, zs1 = 8'h00, zs2 = 8'h00;
   logic [3:0]      req = 4'h0, asg = 4'h0, tol = 4'h0, fb_n, ctl;
   lcz_start_mode_t mode = LCZ_START_NONE;
   lcz_time_cfg_t   tcfg = {9'h000, 9'h004, 9'h002};
   lcz_beam_sig_t   bsig;
   int              n_fail = 0, n_compared = 0;
   lcz_zone_start #(.NUM_BEAMS(8), .TICK_CYC(4)) u_dut (
      .REF_CLK(clk), .NRST(nrst), .CE(ce), .BEAM_BLOCKED(beam), .CTL_IN(ctl),
      .START_BTN(btn), .SAFETY_CIRCUIT_CLOSED(circ), .CTL_ASSIGNED(asg), .ZONE_FIXED(zfix),
      .ZONE_FLOAT(zflt), .ZONE_REDRES(zred), .ZONE_SIG1(zs1), .ZONE_SIG2(zs2),
      .TOL_BEAMS(tol), .START_MODE(mode), .RESTART_MANUAL(man), .SAFETY_CIRCUIT_USED(cused),
      .TIME_CFG(tcfg), .SAFETY_SWITCHING_OUTPUT(sso), .BEAM_SIG(bsig),
      .CTL_FEEDBACK_N(fb_n), .FIELD_FREE(ffree), .LOCKED(lck), .STARTUP_DONE(done));
   lcz_plc_model u_plc (.clk(clk), .nrst(nrst), .req(req), .fb_n(fb_n), .ctl(ctl),
      .fb_err(fb_err));
   always #4 clk = ~clk;
   //////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rst(input lcz_start_mode_t m);
      nrst = 1'h0;
      mode = m;
      asg = 4'h0;
      req = 4'h0;
      cyc(10);
      nrst = 1'h1;
      cyc(8);
   endtask
   task automatic hit(input logic [7:0] b, input int n);
      beam = b;
      cyc(n);
      beam = 8'h00;
      cyc(8);
   endtask
   task automatic push(input int n);
      btn = 1'h1;
      cyc(n);
      btn = 1'h0;
      cyc(20);
   endtask
   task automatic t_none();
      rst(LCZ_START_NONE);
      zs1 = 8'h0F;
      zs2 = 8'h0C;
      chk("sso", sso, 8'h01);
      // beam 0 lies in zone 1 only, so zone 2 must stay quiet
      beam = 8'h01;
      cyc(4);
      chk("sso", sso, 8'h00);
      chk("bsig", bsig, 8'h02);
      beam = 8'h08;
      cyc(4);
      chk("bsig", bsig, 8'h03);
      asg = 4'h8;
      cyc(2);
      chk("bsig", bsig, 8'h00);
      asg = 4'h0;
      beam = 8'h00;
      cyc(4);
      chk("sso", sso, 8'h00);
      cyc(16);
      chk("sso", sso, 8'h01);
      cused = 1'h1;
      circ = 1'h0;
      cyc(4);
      chk("sso", sso, 8'h00);
      circ = 1'h1;
   endtask
   task automatic t_blank();
      rst(LCZ_START_NONE);
      zfix = 8'h80;
      zred = 8'h30;
      tol = 4'h1;
      zflt = 8'h40;
      beam = 8'hD0;
      cyc(4);
      chk("free", ffree, 8'h01);
      beam = 8'h30;
      cyc(4);
      chk("free", ffree, 8'h00);
      beam = 8'h80;
      asg = 4'h1;
      cyc(4);
      chk("free", ffree, 8'h00);
      req = 4'h1;
      cyc(5);
      chk("free", ffree, 8'h01);
      chk("fb", fb_n, 8'h0E);
      beam = 8'h00;
   endtask
   task automatic t_intv();
      tcfg.intv_min = 9'h002;
      rst(LCZ_START_INTV);
      hit(8'h01, 2);
      chk("done", done, 8'h00);
      hit(8'h01, 40);
      chk("done", done, 8'h00);
      hit(8'h01, 12);
      chk("sso", sso, 8'h01);
   endtask
   task automatic t_btn();
      rst(LCZ_START_BTN);
      push(4);
      chk("done", done, 8'h00);
      push(40);
      chk("done", done, 8'h01);
      man = 1'h1;
      asg = 4'h2;
      cyc(6);
      chk("lock", lck, 8'h01);
      push(40);
      chk("lock", lck, 8'h00);
   endtask
   task automatic t_ce();
      cused = 1'h0;
      man = 1'h0;
      rst(LCZ_START_NONE);
      // frozen clock enable must hide the new violation
      ce = 1'h0;
      beam = 8'h01;
      cyc(6);
      chk("free", ffree, 8'h01);
      chk("sso", sso, 8'h01);
      ce = 1'h1;
      cyc(4);
      chk("free", ffree, 8'h00);
      chk("sso", sso, 8'h00);
      beam = 8'h00;
   endtask
   task automatic complete_run();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      t_none();
      t_blank();
      t_intv();
      t_btn();
      t_ce();
      chk("fb_err", fb_err, 8'h00);
      complete_run();
   end
   initial begin
      #60000;
      n_fail++;
      complete_run();
   end
endmodule
